// [verilog/tmm_pkg.sv]
// Function
// - Clock source 0 stops, 1 counts each clock, 2..5 divide by 8/64/256/1024
// - Source 6 counts falling, 7 rising external edges, synchronised first
// - External pin edges count even while that pin is driven as output
// - Software reads and writes the 8-bit count, a write replaces it
// - A count write suppresses the compare match on the next timer tick
// - Compare value is compared on each timer tick; a match feeds irq and waveform
// - Mask bit 7, global enable and compare flag together raise compare irq
// - Mask bit 6, global enable and overflow flag together raise overflow irq
// - Flag bit 7 sets on match, clears by vector ack or written one
// - Flag bit 6 sets on overflow, clears by vector ack or written one
// - Phase correct mode sets overflow on direction change at zero
// - Shared pin takes compare outputs when either mode field is nonzero
// - Both compare outputs enabled turns the modulator on automatically
// - Active modulator combines both compare outputs by AND or OR
// - Direction bit alone decides whether the shared pin is driven
// - Modulator inputs are 16-bit channel C and the 8-bit compare output
// - Modulator is unavailable in legacy compatibility mode
package tmm_pkg;

	localparam logic [4:0] TMM_OFS_COUNT   = 5'h00;
	localparam logic [4:0] TMM_OFS_COMPARE = 5'h04;
	localparam logic [4:0] TMM_OFS_MASK    = 5'h08;
	localparam logic [4:0] TMM_OFS_FLAGS   = 5'h0c;
	localparam logic [4:0] TMM_OFS_CTRL    = 5'h10;
	localparam logic [4:0] TMM_OFS_PIN     = 5'h14;

	localparam int TMM_BIT_CMP      = 7;
	localparam int TMM_BIT_OVF      = 6;
	localparam int TMM_BIT_PIN_DATA = 0;
	localparam int TMM_BIT_PIN_DIR  = 1;

	localparam logic [7:0] TMM_RST_COUNT   = 8'h00;
	localparam logic [7:0] TMM_RST_COMPARE = 8'h00;
	localparam logic [7:0] TMM_RST_MASK    = 8'h00;
	localparam logic [2:0] TMM_RST_CTRL    = 3'h0;
	localparam logic [7:0] TMM_COUNT_MAX   = 8'hff;

	localparam logic [2:0] TMM_CS_STOP = 3'h0;
	localparam logic [2:0] TMM_CS_DIV1 = 3'h1;
	localparam logic [2:0] TMM_CS_D8   = 3'h2;
	localparam logic [2:0] TMM_CS_D64  = 3'h3;
	localparam logic [2:0] TMM_CS_D256 = 3'h4;
	localparam logic [2:0] TMM_CS_D1K  = 3'h5;
	localparam logic [2:0] TMM_CS_FALL = 3'h6;
	localparam logic [2:0] TMM_CS_RISE = 3'h7;

	localparam logic [9:0] TMM_PRE_M8   = 10'h007;
	localparam logic [9:0] TMM_PRE_M64  = 10'h03f;
	localparam logic [9:0] TMM_PRE_M256 = 10'h0ff;
	localparam logic [9:0] TMM_PRE_M1K  = 10'h3ff;

	typedef enum logic [1:0]
	{
		TMM_IDLE = 2'b01,
		TMM_ACK  = 2'b10
	} tmm_bus_state_t;

	typedef struct packed
	{
		logic compare_match;
		logic overflow;
	} tmm_events_t;

	typedef struct packed
	{
		logic [1:0] mode_16bit_c;
		logic [1:0] mode_8bit;
	} tmm_modes_t;

endpackage

// [verilog/tmm_timer.sv]
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module tmm_timer
(
	// Clock, reset, enable
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 clk_en,
	// Avalon-MM slave
	input  wire logic [4:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	// Cpu side
	input  wire logic                 global_irq_enable,
	input  wire logic                 compare_vector_ack,
	input  wire logic                 overflow_vector_ack,
	input  wire logic                 legacy_mode,
	output logic                      compare_irq,
	output logic                      overflow_irq,
	// Waveform unit side
	input  wire logic                 phase_correct_mode,
	input  wire tmm_pkg::tmm_modes_t  compare_output_mode,
	input  wire logic                 carrier_compare_output,
	input  wire logic                 modulating_compare_output,
	output tmm_pkg::tmm_events_t      timer_events,
	// Pins
	input  wire logic                 external_count_input,
	output logic                      shared_output_pin,
	output logic                      shared_output_pin_oe
);

	tmm_pkg::tmm_bus_state_t bus_state_r;
	logic [7:0]              count_value_r;
	logic [7:0]              compare_value_r;
	logic [7:0]              timer_irq_mask_r;
	logic                    compare_match_flag_r;
	logic                    overflow_flag_r;
	logic [2:0]              clock_source_select_r;
	logic                    shared_pin_data_bit_r;
	logic                    shared_pin_direction_bit_r;
	logic [9:0]              prescale_r;
	logic                    ext_sync1_r;
	logic                    ext_sync2_r;
	logic                    ext_prev_r;
	logic                    count_down_r;
	logic                    block_match_r;

	logic                    acc_write;
	logic                    wr_lo;
	logic                    count_wr;
	logic                    flags_wr;
	logic                    tick;
	logic                    match;
	logic                    wrap;
	logic                    reverse_zero;
	logic                    overflow;
	logic [7:0]              count_nxt;
	logic [31:0]             read_mux;
	logic                    cmp_en;
	logic                    mod_en;
	logic                    modulator_on;
	logic                    pin_nxt;

	assign acc_write = avs_write && (bus_state_r == tmm_pkg::TMM_ACK);
	assign wr_lo     = acc_write && avs_byteenable[0];
	assign count_wr  = wr_lo && (avs_address == tmm_pkg::TMM_OFS_COUNT);
	assign flags_wr  = wr_lo && (avs_address == tmm_pkg::TMM_OFS_FLAGS);

	// Bus handshake, one wait cycle
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bus_state_r     <= tmm_pkg::TMM_IDLE;
			avs_waitrequest <= 1'b1;
		end
		else if (clk_en)
		begin
			case (bus_state_r)
				tmm_pkg::TMM_IDLE:
				begin
					if (avs_read || avs_write)
					begin
						bus_state_r     <= tmm_pkg::TMM_ACK;
						avs_waitrequest <= 1'b0;
					end
				end
				tmm_pkg::TMM_ACK:
				begin
					bus_state_r     <= tmm_pkg::TMM_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default:
				begin
					bus_state_r     <= tmm_pkg::TMM_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	always_comb
	begin
		read_mux = 32'h0000_0000;
		case (avs_address)
			tmm_pkg::TMM_OFS_COUNT:   read_mux[7:0] = count_value_r;
			tmm_pkg::TMM_OFS_COMPARE: read_mux[7:0] = compare_value_r;
			tmm_pkg::TMM_OFS_MASK:    read_mux[7:0] = timer_irq_mask_r;
			tmm_pkg::TMM_OFS_FLAGS:
			begin
				read_mux[tmm_pkg::TMM_BIT_CMP] = compare_match_flag_r;
				read_mux[tmm_pkg::TMM_BIT_OVF] = overflow_flag_r;
			end
			tmm_pkg::TMM_OFS_CTRL:    read_mux[2:0] = clock_source_select_r;
			tmm_pkg::TMM_OFS_PIN:
			begin
				read_mux[tmm_pkg::TMM_BIT_PIN_DATA] = shared_pin_data_bit_r;
				read_mux[tmm_pkg::TMM_BIT_PIN_DIR]  = shared_pin_direction_bit_r;
			end
			default:                  read_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			avs_readdata <= 32'h0000_0000;
		end
		else if (clk_en && (bus_state_r == tmm_pkg::TMM_IDLE) && avs_read)
		begin
			avs_readdata <= read_mux;
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			compare_value_r            <= tmm_pkg::TMM_RST_COMPARE;
			timer_irq_mask_r           <= tmm_pkg::TMM_RST_MASK;
			clock_source_select_r      <= tmm_pkg::TMM_RST_CTRL;
			shared_pin_data_bit_r      <= 1'b0;
			shared_pin_direction_bit_r <= 1'b0;
		end
		else if (clk_en && wr_lo)
		begin
			case (avs_address)
				tmm_pkg::TMM_OFS_COMPARE:
				begin
					compare_value_r <= avs_writedata[7:0];
				end
				tmm_pkg::TMM_OFS_MASK:
				begin
					timer_irq_mask_r <= avs_writedata[7:0];
				end
				tmm_pkg::TMM_OFS_CTRL:
				begin
					clock_source_select_r <= avs_writedata[2:0];
				end
				tmm_pkg::TMM_OFS_PIN:
				begin
					shared_pin_data_bit_r      <= avs_writedata[tmm_pkg::TMM_BIT_PIN_DATA];
					shared_pin_direction_bit_r <= avs_writedata[tmm_pkg::TMM_BIT_PIN_DIR];
				end
				default:
				begin
					compare_value_r <= compare_value_r;
				end
			endcase
		end
	end

	// Prescaler
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			prescale_r <= 10'h000;
		end
		else if (clk_en)
		begin
			prescale_r <= prescale_r + 10'h001;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ext_sync1_r <= 1'b0;
			ext_sync2_r <= 1'b0;
			ext_prev_r  <= 1'b0;
		end
		else if (clk_en)
		begin
			ext_sync1_r <= external_count_input;
			ext_sync2_r <= ext_sync1_r;
			ext_prev_r  <= ext_sync2_r;
		end
	end

	always_comb
	begin
		tick = 1'b0;
		case (clock_source_select_r)
			tmm_pkg::TMM_CS_STOP: tick = 1'b0;
			tmm_pkg::TMM_CS_DIV1: tick = 1'b1;
			tmm_pkg::TMM_CS_D8:   tick = (prescale_r[2:0] == tmm_pkg::TMM_PRE_M8[2:0]);
			tmm_pkg::TMM_CS_D64:  tick = (prescale_r[5:0] == tmm_pkg::TMM_PRE_M64[5:0]);
			tmm_pkg::TMM_CS_D256: tick = (prescale_r[7:0] == tmm_pkg::TMM_PRE_M256[7:0]);
			tmm_pkg::TMM_CS_D1K:  tick = (prescale_r == tmm_pkg::TMM_PRE_M1K);
			tmm_pkg::TMM_CS_FALL: tick = ext_prev_r && !ext_sync2_r;
			tmm_pkg::TMM_CS_RISE: tick = !ext_prev_r && ext_sync2_r;
			default:              tick = 1'b0;
		endcase
	end

	assign match = tick && (count_value_r == compare_value_r) && !block_match_r;

	assign wrap         = !phase_correct_mode && (count_value_r == tmm_pkg::TMM_COUNT_MAX);
	assign reverse_zero = phase_correct_mode && count_down_r && (count_value_r == 8'h00);
	assign overflow     = tick && (wrap || reverse_zero);

	always_comb
	begin
		count_nxt = count_value_r + 8'h01;
		if (phase_correct_mode && (count_down_r || count_value_r == tmm_pkg::TMM_COUNT_MAX)
			&& !reverse_zero)
		begin
			count_nxt = count_value_r - 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			count_value_r <= tmm_pkg::TMM_RST_COUNT;
			count_down_r  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (count_wr)
			begin
				count_value_r <= avs_writedata[7:0];
			end
			else if (tick)
			begin
				count_value_r <= count_nxt;
				if (!phase_correct_mode || reverse_zero)
				begin
					count_down_r <= 1'b0;
				end
				else if (count_value_r == tmm_pkg::TMM_COUNT_MAX)
				begin
					count_down_r <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			block_match_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (count_wr)
			begin
				block_match_r <= 1'b1;
			end
			else if (tick)
			begin
				block_match_r <= 1'b0;
			end
		end
	end

	// Flags, a set beats a clear
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			compare_match_flag_r <= 1'b0;
			overflow_flag_r      <= 1'b0;
		end
		else if (clk_en)
		begin
			if (match)
			begin
				compare_match_flag_r <= 1'b1;
			end
			else if (compare_vector_ack || (flags_wr && avs_writedata[tmm_pkg::TMM_BIT_CMP]))
			begin
				compare_match_flag_r <= 1'b0;
			end
			if (overflow)
			begin
				overflow_flag_r <= 1'b1;
			end
			else if (overflow_vector_ack || (flags_wr && avs_writedata[tmm_pkg::TMM_BIT_OVF]))
			begin
				overflow_flag_r <= 1'b0;
			end
		end
	end

	// Interrupt requests and waveform events
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			compare_irq  <= 1'b0;
			overflow_irq <= 1'b0;
			timer_events <= '0;
		end
		else if (clk_en)
		begin
			compare_irq  <= compare_match_flag_r && timer_irq_mask_r[tmm_pkg::TMM_BIT_CMP]
				&& global_irq_enable;
			overflow_irq <= overflow_flag_r && timer_irq_mask_r[tmm_pkg::TMM_BIT_OVF]
				&& global_irq_enable;
			timer_events.compare_match <= match;
			timer_events.overflow      <= overflow;
		end
	end

	assign cmp_en = (compare_output_mode.mode_8bit != 2'b00);
	assign mod_en = (compare_output_mode.mode_16bit_c != 2'b00);
	assign modulator_on = cmp_en && mod_en && !legacy_mode;

	always_comb
	begin
		pin_nxt = shared_pin_data_bit_r;
		if (modulator_on)
		begin
			pin_nxt = shared_pin_data_bit_r ?
				(carrier_compare_output || modulating_compare_output) :
				(carrier_compare_output && modulating_compare_output);
		end
		else if (cmp_en)
		begin
			pin_nxt = carrier_compare_output;
		end
		else if (mod_en)
		begin
			pin_nxt = modulating_compare_output;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			shared_output_pin    <= 1'b0;
			shared_output_pin_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			shared_output_pin    <= pin_nxt;
			shared_output_pin_oe <= shared_pin_direction_bit_r;
		end
	end

endmodule

// [bench/tmm_timer_sva.sv]
`timescale 1ns/1ps
module tmm_timer_sva
(
	// Clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rst,
	input wire logic                 clk_en,
	// Bus
	input wire logic                 avs_read,
	input wire logic                 avs_write,
	input wire logic                 avs_waitrequest,
	// Cpu side
	input wire logic                 global_irq_enable,
	input wire logic                 legacy_mode,
	input wire logic                 compare_irq,
	input wire logic                 overflow_irq,
	// Waveform side and pin
	input wire tmm_pkg::tmm_modes_t  compare_output_mode,
	input wire logic                 carrier_compare_output,
	input wire logic                 modulating_compare_output,
	input wire tmm_pkg::tmm_events_t timer_events,
	input wire logic                 shared_output_pin
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	logic m8;
	logic m16;
	assign m8 = |compare_output_mode.mode_8bit;
	assign m16 = |compare_output_mode.mode_16bit_c;

	sequence bus_req;
		(avs_read || avs_write) && avs_waitrequest && clk_en;
	endsequence
	sequence bus_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	bus_answer_a: assert property (bus_req |=> bus_ack)
		else $error("bus answer not one cycle");
	cmp_irq_gate_a: assert property (compare_irq |-> $past(global_irq_enable))
		else $error("compare irq without global enable");
	ovf_irq_gate_a: assert property (overflow_irq |-> $past(global_irq_enable))
		else $error("overflow irq without global enable");
	match_pulse_a: assert property (timer_events.compare_match |=> !timer_events.compare_match)
		else $error("compare event longer than one cycle");
	ovf_pulse_a: assert property (timer_events.overflow |=> !timer_events.overflow)
		else $error("overflow event longer than one cycle");
	mod_agree_a: assert property (m8 && m16 && !legacy_mode &&
		carrier_compare_output == modulating_compare_output |=> shared_output_pin == $past(carrier_compare_output))
		else $error("modulator output wrong");
	carrier_route_a: assert property (m8 && !m16 |=> shared_output_pin == $past(carrier_compare_output))
		else $error("carrier not routed");
	modul_route_a: assert property (!m8 && m16 |=> shared_output_pin == $past(modulating_compare_output))
		else $error("channel c not routed");
	legacy_off_a: assert property (m8 && m16 && legacy_mode |=> shared_output_pin == $past(carrier_compare_output))
		else $error("modulator active in legacy mode");
endmodule

bind tmm_timer tmm_timer_sva u_sva
(
	.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .global_irq_enable(global_irq_enable), .legacy_mode(legacy_mode),
	.compare_irq(compare_irq), .overflow_irq(overflow_irq), .compare_output_mode(compare_output_mode),
	.carrier_compare_output(carrier_compare_output), .modulating_compare_output(modulating_compare_output),
	.timer_events(timer_events), .shared_output_pin(shared_output_pin)
);

// [bench/tmm_pin_model.sv]
`timescale 1ns/1ps
module tmm_pin_model
(
	// Clock and control
	input wire logic ref_clk,
	input wire logic run,
	// Count pin
	output logic     ext_in
);
	logic [1:0] div_r = 2'h0;
	initial ext_in = 1'b0;
	// Pin toggles every four cycles while run is high
	always @(posedge ref_clk)
	begin
		div_r <= run ? div_r + 2'h1 : 2'h0;
		if (run && div_r == 2'h3)
			ext_in <= !ext_in;
	end
endmodule

// [bench/tmm_timer_tb.sv]
`timescale 1ns/1ps
module tmm_timer_tb;
	logic                ref_clk;
	logic                rst;
	logic [4:0]          adr;
	logic                rd;
	logic                wr;
	logic [31:0]         wd;
	logic [31:0]         rdat;
	logic [31:0]         rword;
	logic                wt;
	logic                gie;
	logic                cva;
	logic                lg;
	logic                c_irq;
	logic                o_irq;
	tmm_pkg::tmm_modes_t mode;
	logic                car;
	logic                modl;
	logic                run;
	logic                ext;
	logic                pin;
	logic                oe;
	logic                ce;
	logic                ova;
	logic                pc;
	logic [3:0]          be;
	tmm_pkg::tmm_events_t ev;
	logic [31:0]         r;
	logic [7:0]          cv;
	int                  k;
	int                  error_cnt;
	int                  n_checks;
	int                  n_cm = 0;
	int                  n_ov = 0;
	int                  div [5] = '{1, 8, 64, 256, 1024};

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	tmm_timer u_dut
	(
		.ref_clk(ref_clk), .rst(rst), .clk_en(ce), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
		.global_irq_enable(gie), .compare_vector_ack(cva), .overflow_vector_ack(ova), .legacy_mode(lg),
		.compare_irq(c_irq), .overflow_irq(o_irq), .phase_correct_mode(pc), .compare_output_mode(mode),
		.carrier_compare_output(car), .modulating_compare_output(modl), .timer_events(ev),
		.external_count_input(ext), .shared_output_pin(pin), .shared_output_pin_oe(oe)
	);

	tmm_pin_model u_pin
	(
		.ref_clk(ref_clk), .run(run), .ext_in(ext)
	);

	// Count event pulses, value before each edge
	always @(posedge ref_clk)
	begin
		n_cm <= n_cm + int'(ev.compare_match);
		n_ov <= n_ov + int'(ev.overflow);
	end

	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(logic w, logic [4:0] a, logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		adr <= a;
		wd <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do
		begin
			@(posedge ref_clk);
			n++;
			if (n > 20)
			begin
				error_cnt++;
				complete_run();
			end
		end
		while (wt !== 1'b0);
		rword = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic rchk(logic [4:0] a, logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk("readdata", {24'h0, e}, rword);
	endtask

	task automatic burst(logic [7:0] v);
		bus(1'b1, tmm_pkg::TMM_OFS_COUNT, v);
		bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h01);
		repeat (2) @(posedge ref_clk);
		bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h00);
	endtask

	function automatic logic exp_pin(tmm_pkg::tmm_modes_t m, logic l, logic c, logic o, logic d);
		logic a;
		logic b;
		a = |m.mode_8bit;
		b = |m.mode_16bit_c;
		if (a && b && !l)
			return d ? (c | o) : (c & o);
		if (a)
			return c;
		if (b)
			return o;
		return d;
	endfunction

	initial
	begin
		repeat (100000) @(posedge ref_clk);
		error_cnt++;
		complete_run();
	end

	initial
	begin
		rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 5'h00; wd = 32'h0; gie = 1'b0; cva = 1'b0;
		lg = 1'b0; mode = 4'h0; car = 1'b0; modl = 1'b0; run = 1'b0; error_cnt = 0; n_checks = 0;
		ce = 1'b1;
		ova = 1'b0;
		pc = 1'b0;
		be = 4'hf;
		void'($urandom(29474));
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rchk(tmm_pkg::TMM_OFS_COUNT, tmm_pkg::TMM_RST_COUNT);
		rchk(tmm_pkg::TMM_OFS_COMPARE, tmm_pkg::TMM_RST_COMPARE);
		rchk(tmm_pkg::TMM_OFS_MASK, tmm_pkg::TMM_RST_MASK);
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h00);
		bus(1'b1, 5'h18, 8'hff);
		rchk(5'h18, 8'h00);
		cv = 8'($urandom);
		bus(1'b1, tmm_pkg::TMM_OFS_COUNT, cv);
		repeat (5) @(posedge ref_clk);
		rchk(tmm_pkg::TMM_OFS_COUNT, cv);
		for (int i = 0; i < 5; i++)
		begin
			k = $urandom_range(9, 4);
			bus(1'b1, tmm_pkg::TMM_OFS_COUNT, 8'h00);
			bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'(i + 1));
			repeat (div[i] * k - 3) @(posedge ref_clk);
			bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h00);
			rchk(tmm_pkg::TMM_OFS_COUNT, 8'(k));
		end
		for (int s = 7; s > 5; s--)
		begin
			k = $urandom_range(6, 2);
			bus(1'b1, tmm_pkg::TMM_OFS_COUNT, 8'h00);
			bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'(s));
			run <= 1'b1;
			repeat (8 * k + 2) @(posedge ref_clk);
			run <= 1'b0;
			repeat (8) @(posedge ref_clk);
			bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h00);
			rchk(tmm_pkg::TMM_OFS_COUNT, 8'(k));
		end
		cv = 8'($urandom_range(200, 8));
		gie <= 1'b1;
		bus(1'b1, tmm_pkg::TMM_OFS_MASK, 8'hc0);
		rchk(tmm_pkg::TMM_OFS_MASK, 8'hc0);
		bus(1'b1, tmm_pkg::TMM_OFS_COMPARE, cv);
		bus(1'b1, tmm_pkg::TMM_OFS_COUNT, cv);
		bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h01);
		bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h00);
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h00);
		burst(cv - 8'h03);
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h80);
		chk("compare_irq", 1, c_irq);
		chk("overflow_irq", 0, o_irq);
		gie <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("compare_irq", 0, c_irq);
		gie <= 1'b1;
		bus(1'b1, tmm_pkg::TMM_OFS_FLAGS, 8'h80);
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h00);
		burst(cv - 8'h03);
		cva <= 1'b1;
		@(posedge ref_clk);
		cva <= 1'b0;
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h00);
		burst(8'hfd);
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h40);
		chk("overflow_irq", 1, o_irq);
		bus(1'b1, tmm_pkg::TMM_OFS_FLAGS, 8'h40);
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h00);
		// up to top, down to zero, turn
		pc <= 1'b1;
		bus(1'b1, tmm_pkg::TMM_OFS_COUNT, 8'hfd);
		bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h01);
		repeat (257) @(posedge ref_clk);
		bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h00);
		pc <= 1'b0;
		rchk(tmm_pkg::TMM_OFS_COUNT, 8'h03);
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'hc0);
		ova <= 1'b1;
		@(posedge ref_clk);
		ova <= 1'b0;
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h80);
		chk("compare_events", 3, n_cm);
		chk("overflow_events", 2, n_ov);
		bus(1'b1, tmm_pkg::TMM_OFS_FLAGS, 8'h80);
		rchk(tmm_pkg::TMM_OFS_FLAGS, 8'h00);
		// Write without low byte lane is ignored
		be <= 4'h0;
		bus(1'b1, tmm_pkg::TMM_OFS_COMPARE, 8'h11);
		be <= 4'hf;
		rchk(tmm_pkg::TMM_OFS_COMPARE, cv);
		// Clock enable low freezes the counter
		bus(1'b1, tmm_pkg::TMM_OFS_COUNT, 8'h00);
		bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h01);
		ce <= 1'b0;
		repeat (10) @(posedge ref_clk);
		ce <= 1'b1;
		bus(1'b1, tmm_pkg::TMM_OFS_CTRL, 8'h00);
		rchk(tmm_pkg::TMM_OFS_COUNT, 8'h03);
		for (int i = 0; i < 40; i++)
		begin
			r = $urandom;
			bus(1'b1, tmm_pkg::TMM_OFS_PIN, {6'h00, r[8:7]});
			mode <= r[3:0];
			car <= r[4];
			modl <= r[5];
			lg <= r[6];
			repeat (3) @(posedge ref_clk);
			chk("pin", exp_pin(mode, lg, car, modl, r[7 + tmm_pkg::TMM_BIT_PIN_DATA]), pin);
			chk("pin_oe", r[7 + tmm_pkg::TMM_BIT_PIN_DIR], oe);
		end
		complete_run();
	end
endmodule
